// File: core/trsf_fifo.sv
// Purpose: small buffer between the transaction layer and the streaming output
// Assumes: synchronous active-high reset, single clock
// Notes:   read data come from a register; no write-to-read bypass, one extra cycle traded for timing
`timescale 1ns/1ps
module trsf_fifo
    import trsf_pkg::*;
#(
    parameter int W     = TRSF_BEAT_W,
    parameter int DEPTH = TRSF_FIFO_DEP
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          in_ready_r, in_ready_nxt;
    logic          out_valid_r, out_valid_nxt;
    logic [W-1:0]  out_data_r, out_data_nxt;
    logic          push, load;

    // pointer, level and output register next values
    always_comb begin
        push          = in_valid && in_ready_r;
        load          = (!out_valid_r || out_ready) && (cnt_r != '0);
        wr_ptr_nxt    = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt    = load ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
        cnt_nxt       = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
        in_ready_nxt  = cnt_nxt != FULL_CNT;   // honest full, registered
        out_valid_nxt = load ? 1'b1 : (out_ready ? 1'b0 : out_valid_r);
        out_data_nxt  = load ? mem_r[rd_ptr_r] : out_data_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            cnt_r       <= '0;
            in_ready_r  <= 1'b0;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else begin
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            cnt_r       <= cnt_nxt;
            in_ready_r  <= in_ready_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r  <= out_data_nxt;
        end
    end

    // storage carries no reset, contents are qualified by the level
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    assign in_ready  = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;
endmodule

// File: core/trsf_rx_framer.sv
// Purpose: receive streaming framer handing packets to the application side
// Assumes: 20 MHz clk, synchronous active-high rst, upstream beats already laid out
// Notes:   consumer accept is honoured with a fixed latency of two cycles
`timescale 1ns/1ps
module trsf_rx_framer
    import trsf_pkg::*;
#(
    parameter int DATA_W     = 256,
    parameter bit MULTI_PKT  = 1'b1,
    parameter int FIFO_DEPTH = TRSF_FIFO_DEP,
    parameter int SOP_W      = (DATA_W == TRSF_MAX_W && MULTI_PKT) ? 2 : 1,
    parameter int EMPTY_W    = (DATA_W == TRSF_MAX_W) ? 2 : 1
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire trsf_beat_t  tl_beat,
    input  wire logic        tl_beat_valid,
    output logic             tl_beat_ready,
    output logic [DATA_W-1:0]  rx_packet_bus,
    output logic [SOP_W-1:0]   rx_first_beat_flag,
    output logic [SOP_W-1:0]   rx_last_beat_flag,
    output logic [EMPTY_W-1:0] rx_unused_qword_count,
    output logic             rx_beat_qualifier,
    input  wire logic        rx_sink_accept,
    output logic             reset_status
);
    // tidy an incoming beat to the configured geometry
    function automatic trsf_beat_t trsf_clean(input trsf_beat_t b);
        trsf_beat_t c;
        c = b;
        c.data = b.data & TRSF_MAX_W'({DATA_W{1'b1}});
        if (SOP_W == 1) begin
            c.first = {1'b0, |b.first};
            c.last  = {1'b0, |b.last};
        end
        if (DATA_W == TRSF_QWORD_W) begin
            c.unused = TRSF_EMPTY_NONE;
        end else if (DATA_W == TRSF_HALF_W) begin
            c.unused = c.last[0] ? {1'b0, b.unused[0]} : TRSF_EMPTY_NONE;
        end else if (MULTI_PKT) begin
            c.unused = b.unused & b.last;
        end else begin
            c.unused = |b.last ? b.unused : TRSF_EMPTY_NONE;
        end
        return c;
    endfunction

    // embedded reset controller state
    trsf_rc_state_t           rc_state_r, rc_state_nxt;
    logic [TRSF_RC_CNT_W-1:0] rc_cnt_r, rc_cnt_nxt;
    logic                     soft_rst_r, soft_rst_nxt;
    logic                     core_rst;

    // cold hold, then soft hold, then run; no external cold or soft pins
    always_comb begin
        rc_state_nxt = rc_state_r;
        rc_cnt_nxt   = rc_cnt_r;
        soft_rst_nxt = 1'b1;
        unique case (rc_state_r)
            TRSF_RC_COLD: begin
                if (rc_cnt_r == TRSF_RC_CNT_W'(TRSF_COLD_CYC - 1)) begin
                    rc_state_nxt = TRSF_RC_SOFT;
                    rc_cnt_nxt   = '0;
                end else begin
                    rc_cnt_nxt = TRSF_RC_CNT_W'(rc_cnt_r + 1'b1);
                end
            end
            TRSF_RC_SOFT: begin
                if (rc_cnt_r == TRSF_RC_CNT_W'(TRSF_SOFT_CYC - 1)) begin
                    rc_state_nxt = TRSF_RC_RUN;
                    soft_rst_nxt = 1'b0;
                end else begin
                    rc_cnt_nxt = TRSF_RC_CNT_W'(rc_cnt_r + 1'b1);
                end
            end
            TRSF_RC_RUN: begin
                soft_rst_nxt = 1'b0;
            end
            default: begin
                rc_state_nxt = TRSF_RC_COLD;
                rc_cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rc_state_r <= TRSF_RC_COLD;
            rc_cnt_r   <= '0;
            soft_rst_r <= 1'b1;
        end else begin
            rc_state_r <= rc_state_nxt;
            rc_cnt_r   <= rc_cnt_nxt;
            soft_rst_r <= soft_rst_nxt;
        end
    end

    // outputs must reset with the pin too, not one cycle late
    assign core_rst = rst || soft_rst_r;

    // buffer between transaction layer and the consumer
    trsf_beat_t fifo_out;
    logic       fifo_out_valid;
    logic       fifo_pop;
    logic       fifo_in_ready;

    trsf_fifo #(
        .W     (TRSF_BEAT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (core_rst),
        .in_data   (trsf_clean(tl_beat)),
        .in_valid  (tl_beat_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // output stage and accept delay line
    logic                acc_d1_r, acc_d1_nxt;
    logic                qual_r, qual_nxt;
    logic [DATA_W-1:0]   bus_r, bus_nxt;
    logic [SOP_W-1:0]    first_r, first_nxt;
    logic [SOP_W-1:0]    last_r, last_nxt;
    logic [EMPTY_W-1:0]  unused_r, unused_nxt;

    // a beat leaves only if accept was seen two cycles before it shows
    always_comb begin
        acc_d1_nxt = rx_sink_accept;
        fifo_pop   = acc_d1_r && fifo_out_valid;
        qual_nxt   = fifo_pop;
        bus_nxt    = fifo_pop ? fifo_out.data[DATA_W-1:0] : bus_r;
        first_nxt  = fifo_pop ? fifo_out.first[SOP_W-1:0] : '0;
        last_nxt   = fifo_pop ? fifo_out.last[SOP_W-1:0] : '0;
        unused_nxt = fifo_pop ? fifo_out.unused[EMPTY_W-1:0] : '0;
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            acc_d1_r   <= 1'b0;
            qual_r     <= 1'b0;
            bus_r      <= '0;
            first_r    <= '0;
            last_r     <= '0;
            unused_r   <= '0;
        end else begin
            acc_d1_r   <= acc_d1_nxt;
            qual_r     <= qual_nxt;
            bus_r      <= bus_nxt;
            first_r    <= first_nxt;
            last_r     <= last_nxt;
            unused_r   <= unused_nxt;
        end
    end

    // upstream ready is the buffer's own registered level, so it always matches the push gate
    assign tl_beat_ready         = fifo_in_ready;
    assign rx_packet_bus         = bus_r;
    assign rx_first_beat_flag    = first_r;
    assign rx_last_beat_flag     = last_r;
    assign rx_unused_qword_count = unused_r;
    assign rx_beat_qualifier     = qual_r;
    assign reset_status          = soft_rst_r;

    // checks
    sequence seq_accept_pending;
        rx_sink_accept ##1 fifo_out_valid;
    endsequence

    lat_two_a: assert property (@(posedge clk) disable iff (core_rst)
        rx_beat_qualifier |-> $past(rx_sink_accept, 2))
        else $error("beat presented without accept two cycles earlier");

    drop_valid_a: assert property (@(posedge clk) disable iff (core_rst)
        !rx_sink_accept |-> ##2 !rx_beat_qualifier)
        else $error("qualifier still high two cycles after accept loss");

    resume_a: assert property (@(posedge clk) disable iff (core_rst)
        seq_accept_pending |=> rx_beat_qualifier)
        else $error("qualifier not restored with data pending");

    sop_qual_a: assert property (@(posedge clk) disable iff (core_rst)
        (|rx_first_beat_flag) |-> rx_beat_qualifier)
        else $error("start flag without qualifier");

    eop_qual_a: assert property (@(posedge clk) disable iff (core_rst)
        (|rx_last_beat_flag) |-> rx_beat_qualifier)
        else $error("end flag without qualifier");

    empty_eop_a: assert property (@(posedge clk) disable iff (core_rst)
        (rx_unused_qword_count != '0) |-> (|rx_last_beat_flag))
        else $error("unused count without end flag");

    data_pass_a: assert property (@(posedge clk) disable iff (core_rst)
        fifo_pop |=> rx_packet_bus == $past(fifo_out.data[DATA_W-1:0])
                     && rx_last_beat_flag == $past(fifo_out.last[SOP_W-1:0]))
        else $error("beat altered on its way out");

    rstctl_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> reset_status ##[14:16] !reset_status)
        else $error("internal reset sequence length wrong");
endmodule

// File: pkg/trsf_pkg.sv
// Purpose: shared constants and types of the receive packet framer
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes:   beat carrier is sized for the widest bus, narrower variants use the low bits
package trsf_pkg;
    // bus geometry
    localparam int TRSF_MAX_W    = 256;
    localparam int TRSF_HALF_W   = 128;
    localparam int TRSF_QWORD_W  = 64;
    localparam int TRSF_FLAG_W   = 2;
    localparam int TRSF_FIFO_DEP = 8;

    // unused-qword and flag encodings
    localparam logic [1:0] TRSF_EMPTY_NONE = 2'h0;
    localparam logic [1:0] TRSF_FLAG_NONE  = 2'h0;

    // handshake timing
    localparam int TRSF_READY_LAT = 2;

    // embedded reset controller timing
    localparam int TRSF_CLK_MHZ      = 20;
    localparam int TRSF_COLD_HOLD_NS = 500;
    localparam int TRSF_SOFT_HOLD_NS = 200;
    localparam int TRSF_COLD_CYC     = (TRSF_COLD_HOLD_NS * TRSF_CLK_MHZ + 999) / 1000;
    localparam int TRSF_SOFT_CYC     = (TRSF_SOFT_HOLD_NS * TRSF_CLK_MHZ + 999) / 1000;
    localparam int TRSF_RC_CNT_W     = 8;

    // one received beat as it travels through the buffer
    typedef struct packed {
        logic [TRSF_MAX_W-1:0]  data;
        logic [TRSF_FLAG_W-1:0] first;
        logic [TRSF_FLAG_W-1:0] last;
        logic [TRSF_FLAG_W-1:0] unused;
    } trsf_beat_t;

    localparam int TRSF_BEAT_W = $bits(trsf_beat_t);

    // reset controller states
    typedef enum logic [2:0] {
        TRSF_RC_COLD = 3'b001,
        TRSF_RC_SOFT = 3'b010,
        TRSF_RC_RUN  = 3'b100
    } trsf_rc_state_t;
endpackage

// File: verification/trsf_rx_framer_tb.sv
// Purpose: self-checking bench of the receive framer, wide multi-packet build
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   a monitor compares every qualified beat with the pushed order; a 128-bit copy runs in lockstep
`timescale 1ns/1ps
module trsf_rx_framer_tb
    import trsf_pkg::*;
;
    logic         clk, rst, tl_beat_valid, tl_beat_ready, rx_beat_qualifier, rx_sink_accept, reset_status;
    trsf_beat_t   tl_beat, exp_b;
    logic [255:0] rx_packet_bus;
    logic [1:0]   first_f, last_f, unused_f, mode, acc_h;
    logic [127:0] nar_bus;
    logic         nar_first, nar_last, nar_unused, nar_qual;
    int           miscompares, cmp_count, beat_cnt;
    trsf_beat_t   exp_q[$];
    // start/end/unused per half: {first, last, unused}
    logic [5:0]   tbl[6] = '{6'h10, 6'h05, 6'h37, 6'h0A, 6'h20, 6'h2F};

    trsf_rx_framer #(.DATA_W(256), .MULTI_PKT(1'b1), .FIFO_DEPTH(TRSF_FIFO_DEP)) i_dut (
        .clk(clk), .rst(rst), .tl_beat(tl_beat), .tl_beat_valid(tl_beat_valid),
        .tl_beat_ready(tl_beat_ready), .rx_packet_bus(rx_packet_bus), .rx_first_beat_flag(first_f),
        .rx_last_beat_flag(last_f), .rx_unused_qword_count(unused_f),
        .rx_beat_qualifier(rx_beat_qualifier), .rx_sink_accept(rx_sink_accept), .reset_status(reset_status));

    trsf_sink_model i_sink (.clk(clk), .rst(rst), .mode(mode), .rx_beat_qualifier(rx_beat_qualifier),
        .rx_sink_accept(rx_sink_accept), .beat_cnt(beat_cnt));

    // narrow single-packet copy: same buffer timing, folded flags and one unused bit
    trsf_rx_framer #(.DATA_W(128), .MULTI_PKT(1'b0), .FIFO_DEPTH(TRSF_FIFO_DEP)) i_dut_128 (
        .clk(clk), .rst(rst), .tl_beat(tl_beat), .tl_beat_valid(tl_beat_valid),
        .tl_beat_ready(), .rx_packet_bus(nar_bus), .rx_first_beat_flag(nar_first),
        .rx_last_beat_flag(nar_last), .rx_unused_qword_count(nar_unused),
        .rx_beat_qualifier(nar_qual), .rx_sink_accept(rx_sink_accept), .reset_status());

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    function automatic trsf_beat_t mk(input int i, input logic [5:0] f);
        trsf_beat_t b;
        b.data = {8{32'hB0000000 | 32'(i)}};
        {b.first, b.last, b.unused} = f;
        return b;
    endfunction

    // monitor: qualified beats come in push order, idle cycles carry no flags
    always @(posedge clk) begin
        if (rst) acc_h <= 2'h0;
        else begin
            acc_h <= {acc_h[0], rx_sink_accept};
            if (rx_beat_qualifier === 1'b1) begin
                check(256'(acc_h[1]), 256'h1);
                check(256'(nar_qual), 256'h1);
                if (exp_q.size() == 0) check(256'h1, 256'h0);
                else begin
                    exp_b = exp_q.pop_front();
                    check(rx_packet_bus, exp_b.data);
                    check(256'(first_f), 256'(exp_b.first));
                    check(256'(last_f), 256'(exp_b.last));
                    check(256'(unused_f), 256'(exp_b.unused & exp_b.last));
                    check(256'(nar_bus), 256'(exp_b.data[127:0]));
                    check(256'({nar_first, nar_last}), 256'({|exp_b.first, |exp_b.last}));
                    check(256'(nar_unused), 256'((|exp_b.last) & exp_b.unused[0]));
                end
            end else begin
                check(256'({first_f, last_f, unused_f}), 256'h0);
                check(256'({nar_qual, nar_first, nar_last, nar_unused}), 256'h0);
            end
        end
    end

    // valid stays up between pushes; the caller lowers it once at the end
    task automatic push(input trsf_beat_t b, input int tries, output bit taken);
        taken = 1'b0;
        tl_beat = b;
        tl_beat_valid = 1'b1;
        for (int i = 0; i < tries && !taken; i++) begin
            taken = (tl_beat_ready === 1'b1);
            @(posedge clk);
            #1;
        end
        if (taken) exp_q.push_back(b);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 200) begin
            miscompares++;
            wrap_up();
        end
        repeat (3) @(posedge clk);
        #1;
    endtask

    // reset_status falls a fixed count of edges after release
    task automatic t_reset();
        int n;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(256'(reset_status), 256'h1);
        check(256'(rx_beat_qualifier), 256'h0);
        rst = 1'b0;
        n = 0;
        while (reset_status !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(256'(n), 256'(TRSF_COLD_CYC + TRSF_SOFT_CYC));
    endtask

    // both halves start and end, with empty upper qwords
    task automatic t_stream(input logic [1:0] m);
        bit ok;
        int n0;
        n0 = beat_cnt;
        mode = m;
        foreach (tbl[i]) begin
            push(mk(i, tbl[i]), 40, ok);
            check(256'(ok), 256'h1);
        end
        tl_beat_valid = 1'b0;
        if (m == 2'h2) begin
            // a consumer that never accepts sees nothing; the beats stay buffered
            repeat (4) @(posedge clk);
            #1;
            check(256'(beat_cnt - n0), 256'h0);
            check(256'(exp_q.size()), 256'h6);
        end else begin
            drain();
            check(256'(beat_cnt - n0), 256'h6);
        end
    endtask

    // consumer stalls until the buffer refuses, then resumes
    task automatic t_fill();
        bit ok;
        int n;
        mode = 2'h2;
        n = 0;
        ok = 1'b1;
        while (ok && n < 12) begin
            push(mk(n + 16, 6'h3F), 3, ok);
            n++;
        end
        check(256'(ok), 256'h0);
        tl_beat_valid = 1'b0;
        mode = 2'h0;
        n = 0;
        while (rx_beat_qualifier !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(256'(n <= 4), 256'h1);
        drain();
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        tl_beat = '0;
        tl_beat_valid = 1'b0;
        mode = 2'h0;
        miscompares = 0;
        cmp_count = 0;
        t_reset();
        t_stream(2'h0);
        t_stream(2'h1);
        t_fill();
        // reset with beats still buffered: none may appear afterwards
        t_stream(2'h2);
        exp_q.delete();
        t_reset();
        mode = 2'h0;
        repeat (20) @(posedge clk);
        #1;
        t_stream(2'h0);
        wrap_up();
    end
endmodule

// File: verification/trsf_sink_model.sv
// Purpose: consumer model taking received beats from the framer
// Assumes: one clock, synchronous active-high reset
// Notes:   mode 0 accepts always, 1 every other cycle, 2 never
`timescale 1ns/1ps
module trsf_sink_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] mode,
    input  wire logic       rx_beat_qualifier,
    output logic            rx_sink_accept,
    output int              beat_cnt
);
    logic toggle_r;

    // accept moves only at the edge, so the block sees it with full latency
    always @(posedge clk) begin
        toggle_r <= rst ? 1'b0 : ~toggle_r;
        rx_sink_accept <= !rst && (mode == 2'h0 || (mode == 2'h1 && toggle_r));
        // unqualified cycles carry nothing worth counting
        if (rst) beat_cnt <= 0;
        else if (rx_beat_qualifier === 1'b1) beat_cnt <= beat_cnt + 1;
    end
endmodule
